// File: tb.sv
// self-checking bench for the ttl input pattern reader
`timescale 1ns/1ps
module tb;
    logic i_clk_sys = 1'b0, i_rstn = 1'b0, i_ce = 1'b1, i_panel_dir_we = 1'b0, i_panel_rd = 1'b0;
    logic [3:0] i_panel_dir = 4'h0, s_axi_wstrb = 4'hF;
    logic [7:0] i_panel_ch = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, lvl = 32'hC324_5AF1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic o_panel_valid, o_panel_in_mark, o_panel_err, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] o_panel_base, s_axi_bresp, s_axi_rresp;
    logic [7:0] o_panel_byte;
    logic [31:0] s_axi_rdata;
    wire logic [31:0] i_ttl;
    // per base: length, prefix, truncated reading of 8'hC3
    logic [5:0] fl [4] = '{6'h02, 6'h03, 6'h01, 6'h02};
    logic [31:0] pfx [4] = '{32'h0, 32'h2342, 32'h2348, 32'h2351};
    logic [31:0] ftr [4] = '{32'hC3, 32'h6, 32'hC, 32'h18};
    int n_mismatch = 0, checked = 0, cyc = 0;
    always #12.5 i_clk_sys = ~i_clk_sys;
    tipr_ttl_src u_tipr_ttl_src (.i_level(lvl), .o_ttl(i_ttl));
    tipr_top u_tipr_top (.i_clk_sys, .i_rstn, .i_ce, .i_ttl, .i_panel_dir_we, .i_panel_dir,
        .i_panel_rd, .i_panel_ch, .o_panel_valid, .o_panel_byte, .o_panel_in_mark,
        .o_panel_base, .o_panel_err, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    task automatic finish_test;
        $display("checked=%0d mismatches=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        // the whole sequence needs a few hundred cycles
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge i_clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // ready is looked at mid-cycle, where it is settled for the coming edge
        while (!(aw && w)) begin
            @(negedge i_clk_sys);
            ta = !aw && s_axi_awready;
            tw = !w && s_axi_wready;
            @(posedge i_clk_sys);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            aw = aw | ta;
            w = w | tw;
        end
        do @(negedge i_clk_sys); while (s_axi_bvalid !== 1'b1);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge i_clk_sys);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge i_clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge i_clk_sys); while (s_axi_arready !== 1'b1);
        @(posedge i_clk_sys);
        s_axi_arvalid <= 1'b0;
        do @(negedge i_clk_sys); while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge i_clk_sys);
        s_axi_rready <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] ch, input tipr_pkg::tipr_width_t w,
        input logic [31:0] pat, input logic err);
        wr(tipr_pkg::ADDR_CMD, {22'h0, w, ch}, tipr_pkg::RESP_OKAY);
        rd(tipr_pkg::ADDR_STAT, {30'h0, 1'b1, err}, tipr_pkg::RESP_OKAY);
        rd(tipr_pkg::ADDR_PAT, pat, tipr_pkg::RESP_OKAY);
    endtask
    // exp is {base, err, mark, byte}
    task automatic pan(input logic [7:0] ch, input logic [11:0] exp);
        @(posedge i_clk_sys);
        i_panel_rd <= 1'b1;
        i_panel_ch <= ch;
        @(posedge i_clk_sys);
        i_panel_rd <= 1'b0;
        @(negedge i_clk_sys);
        chk({19'h0, o_panel_valid, o_panel_base, o_panel_err, o_panel_in_mark, o_panel_byte},
            {19'h0, 1'b1, exp});
    endtask
    initial begin
        repeat (16) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        rd(tipr_pkg::ADDR_DIR, 32'h0, tipr_pkg::RESP_OKAY);
        rd(tipr_pkg::ADDR_FMT, 32'h0, tipr_pkg::RESP_OKAY);
        pan(tipr_pkg::CH_FIRST, 12'h200);
        $display("test reset done");
        wr(tipr_pkg::ADDR_DIR, 32'hF, tipr_pkg::RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            cmd(tipr_pkg::CH_FIRST + 8'(i), tipr_pkg::RD_BYTE, {24'h0, lvl[8*i+:8]}, 1'b0);
        end
        cmd(tipr_pkg::CH_FIRST, tipr_pkg::RD_WORD, 32'h5AF1, 1'b0);
        cmd(tipr_pkg::CH_THIRD, tipr_pkg::RD_WORD, 32'hC324, 1'b0);
        cmd(8'h0C, tipr_pkg::RD_WORD, 32'h0, 1'b1);
        cmd(tipr_pkg::CH_LAST, tipr_pkg::RD_WORD, 32'h0, 1'b1);
        cmd(tipr_pkg::CH_FIRST, tipr_pkg::RD_DWORD, 32'hC324_5AF1, 1'b0);
        cmd(tipr_pkg::CH_THIRD, tipr_pkg::RD_DWORD, 32'h0, 1'b1);
        cmd(8'h0A, tipr_pkg::RD_BYTE, 32'h0, 1'b1);
        cmd(8'h0F, tipr_pkg::RD_BYTE, 32'h0, 1'b1);
        cmd(tipr_pkg::CH_FIRST, tipr_pkg::RD_BAD, 32'h0, 1'b1);
        $display("test remote widths done");
        wr(tipr_pkg::ADDR_DIR, 32'h1, tipr_pkg::RESP_OKAY);
        cmd(8'h0C, tipr_pkg::RD_BYTE, 32'h0, 1'b1);
        cmd(tipr_pkg::CH_FIRST, tipr_pkg::RD_WORD, 32'h0, 1'b1);
        cmd(tipr_pkg::CH_FIRST, tipr_pkg::RD_DWORD, 32'h0, 1'b1);
        lvl <= ~lvl;
        repeat (3) @(posedge i_clk_sys);
        cmd(tipr_pkg::CH_FIRST, tipr_pkg::RD_BYTE, 32'h0E, 1'b0);
        lvl <= ~lvl;
        $display("test direction done");
        @(posedge i_clk_sys);
        i_panel_dir <= 4'hA;
        i_panel_dir_we <= 1'b1;
        @(posedge i_clk_sys);
        i_panel_dir_we <= 1'b0;
        rd(tipr_pkg::ADDR_DIR, 32'hA, tipr_pkg::RESP_OKAY);
        pan(8'h0C, 12'h15A);
        pan(tipr_pkg::CH_FIRST, 12'h200);
        pan(8'h0F, 12'h200);
        pan(tipr_pkg::CH_LAST, 12'h1C3);
        rd(tipr_pkg::ADDR_PANEL, 32'h1C3, tipr_pkg::RESP_OKAY);
        $display("test panel done");
        for (int b = 0; b < 4; b++) begin
            wr(tipr_pkg::ADDR_FMT, {18'h0, fl[b], 6'h0, 2'(b)}, tipr_pkg::RESP_OKAY);
            rd(tipr_pkg::ADDR_CMD, pfx[b], tipr_pkg::RESP_OKAY);
            cmd(tipr_pkg::CH_LAST, tipr_pkg::RD_BYTE, ftr[b], 1'b0);
            pan(tipr_pkg::CH_LAST, {(b == 1) ? 2'h2 : 2'(b), 10'h1C3});
        end
        rd(tipr_pkg::ADDR_FMT, 32'h0203, tipr_pkg::RESP_OKAY);
        wr(tipr_pkg::ADDR_FMT, 32'h2800, tipr_pkg::RESP_OKAY);
        rd(tipr_pkg::ADDR_FMT, 32'h2000, tipr_pkg::RESP_OKAY);
        $display("test format done");
        wr(8'h20, 32'h1, tipr_pkg::RESP_SLVERR);
        rd(8'h20, 32'h0, tipr_pkg::RESP_SLVERR);
        wr(tipr_pkg::ADDR_STAT, 32'h1, tipr_pkg::RESP_SLVERR);
        wr(tipr_pkg::ADDR_PAT, 32'h1, tipr_pkg::RESP_SLVERR);
        // menu write while the enable is low must leave direction untouched
        @(posedge i_clk_sys);
        i_ce <= 1'b0;
        i_panel_dir <= 4'h5;
        i_panel_dir_we <= 1'b1;
        @(posedge i_clk_sys);
        i_panel_dir_we <= 1'b0;
        i_ce <= 1'b1;
        rd(tipr_pkg::ADDR_DIR, 32'hA, tipr_pkg::RESP_OKAY);
        $display("test bus errors done");
        finish_test;
    end
endmodule

// File: tipr_pkg.sv
// shared constants and types for the ttl input pattern reader
package tipr_pkg;
    localparam int PORTS = 4;
    localparam int LINES = 8;
    localparam int PAT_W = 32;
    localparam int DIG_W = 6;
    localparam int LEN_MAX = 32;
    // axi byte addresses
    localparam logic [7:0] ADDR_DIR = 8'h00;
    localparam logic [7:0] ADDR_FMT = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_PAT = 8'h10;
    localparam logic [7:0] ADDR_PANEL = 8'h14;
    localparam logic [7:0] ADDR_PAN_PAT = 8'h18;
    // field positions
    localparam int CMD_PORT_LSB = 0;
    localparam int CMD_WIDTH_LSB = 8;
    localparam int FMT_LEN_LSB = 8;
    localparam int STAT_ERR_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int PAN_MARK_BIT = 8;
    localparam int PAN_BASE_LSB = 9;
    // reset values
    localparam logic [3:0] DIR_RESET = 4'h0;
    localparam logic [DIG_W-1:0] LEN_RESET = 6'h00;
    // channel numbers
    localparam logic [7:0] CH_FIRST = 8'h0B;
    localparam logic [7:0] CH_THIRD = 8'h0D;
    localparam logic [7:0] CH_LAST = 8'h0E;
    // base prefix characters following '#'
    localparam logic [7:0] PFX_BIN = 8'h42;
    localparam logic [7:0] PFX_HEX = 8'h48;
    localparam logic [7:0] PFX_OCT = 8'h51;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        BASE10 = 2'h0,
        BASE2 = 2'h1,
        BASE16 = 2'h2,
        BASE8 = 2'h3
    } tipr_base_t;

    typedef enum logic [1:0] {
        RD_BYTE = 2'h0,
        RD_WORD = 2'h1,
        RD_DWORD = 2'h2,
        RD_BAD = 2'h3
    } tipr_width_t;

    typedef struct packed {
        tipr_base_t base;
        logic [DIG_W-1:0] length;
    } tipr_fmt_t;

    typedef struct packed {
        logic err;
        logic [PAT_W-1:0] pattern;
    } tipr_result_t;
endpackage

// File: tipr_sync.sv
// two-flop synchroniser for one ttl port
`timescale 1ns/1ps
module tipr_sync (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [tipr_pkg::LINES-1:0] i_async,
    output logic [tipr_pkg::LINES-1:0] o_sync
);
    logic [tipr_pkg::LINES-1:0] meta;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            meta <= '0;
            o_sync <= '0;
        end else if (i_ce) begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule

// File: tipr_top.sv
// ttl input pattern reader with axi4-lite registers and front-panel read port
// Operation
// - each input-direction port contributes eight lines, up to thirty-two total
// - ttl high reads as one, ttl low as zero
// - only input-configured ports are read; controller sets direction first
// - line seven is msb, line zero lsb in each port byte
// - byte read accepts channels eleven to fourteen, returns that byte
// - word read accepts only channel eleven or thirteen
// - word joins eleven with twelve, thirteen with fourteen
// - lower port bit zero is word lsb, upper port bit seven bit fifteen
// - double word joins ports eleven to fourteen ascending into 32 bits
// - port eleven bit zero lsb, port fourteen bit seven bit 31
// - results returned in decimal, binary, hex or octal per format
// - one shared format setting for input and output format commands
// - panel reads bytes only; word and double word remote only
// - panel shows decimal, hex, octal; binary shown as hex
// - each of four ports settable to input from local menu
// - panel tags input-port readings with an input marker
// - length zero means full value, else 1..32 digits, lsd truncated in binary, hex and octal only
// - non-decimal results carry a base prefix for bin, hex, octal
`timescale 1ns/1ps
module tipr_top (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [tipr_pkg::PORTS*tipr_pkg::LINES-1:0] i_ttl,
    input wire logic i_panel_dir_we,
    input wire logic [tipr_pkg::PORTS-1:0] i_panel_dir,
    input wire logic i_panel_rd,
    input wire logic [7:0] i_panel_ch,
    output logic o_panel_valid,
    output logic [7:0] o_panel_byte,
    output logic o_panel_in_mark,
    output logic [1:0] o_panel_base,
    output logic o_panel_err,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int W = tipr_pkg::PAT_W;

    logic [W-1:0] ttl_s;
    logic [tipr_pkg::PORTS-1:0] dir_in;
    tipr_pkg::tipr_fmt_t fmt;
    tipr_pkg::tipr_result_t result;
    logic done;
    logic [W-1:0] pfx_word;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic cmd_fire;
    logic [7:0] cmd_ch;
    tipr_pkg::tipr_width_t cmd_w;
    logic next_err;
    logic [W-1:0] next_pat;
    logic [W-1:0] fmt_pat;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    genvar gp;
    generate
        for (gp = 0; gp < tipr_pkg::PORTS; gp++) begin : g_port
            tipr_sync u_sync (
                .i_clk_sys(i_clk_sys),
                .i_rstn(i_rstn),
                .i_ce(i_ce),
                .i_async(i_ttl[gp*tipr_pkg::LINES +: tipr_pkg::LINES]),
                .o_sync(ttl_s[gp*tipr_pkg::LINES +: tipr_pkg::LINES])
            );
        end
    endgenerate

    // axi write channel capture, address and data in either order
    // ready only while enabled, else a handshake would be lost in a frozen cycle
    assign s_axi_awready = i_ce && !aw_held && !s_axi_bvalid;
    assign s_axi_wready = i_ce && !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (i_ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tipr_pkg::RESP_OKAY;
        end else if (i_ce) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                if (aw_addr == tipr_pkg::ADDR_DIR || aw_addr == tipr_pkg::ADDR_FMT ||
                    aw_addr == tipr_pkg::ADDR_CMD) begin
                    s_axi_bresp <= tipr_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= tipr_pkg::RESP_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // direction set by software or local menu, menu wins
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            dir_in <= tipr_pkg::DIR_RESET;
        end else if (i_ce) begin
            if (i_panel_dir_we) begin
                dir_in <= i_panel_dir;
            end else if (wr_fire && aw_addr == tipr_pkg::ADDR_DIR && w_strb[0]) begin
                dir_in <= w_data[tipr_pkg::PORTS-1:0];
            end
        end
    end

    // single format register serves both format commands
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            fmt.base <= tipr_pkg::BASE10;
            fmt.length <= tipr_pkg::LEN_RESET;
        end else if (i_ce) begin
            if (wr_fire && aw_addr == tipr_pkg::ADDR_FMT) begin
                if (w_strb[0]) begin
                    fmt.base <= tipr_pkg::tipr_base_t'(w_data[1:0]);
                end
                if (w_strb[1]) begin
                    if (w_data[tipr_pkg::FMT_LEN_LSB +: 8] > 8'(tipr_pkg::LEN_MAX)) begin
                        fmt.length <= 6'(tipr_pkg::LEN_MAX);
                    end else begin
                        fmt.length <= w_data[tipr_pkg::FMT_LEN_LSB +: tipr_pkg::DIG_W];
                    end
                end
            end
        end
    end

    assign cmd_fire = wr_fire && aw_addr == tipr_pkg::ADDR_CMD && w_strb[0];
    assign cmd_ch = w_data[tipr_pkg::CMD_PORT_LSB +: 8];
    assign cmd_w = tipr_pkg::tipr_width_t'(w_data[tipr_pkg::CMD_WIDTH_LSB +: 2]);

    // remote read decode and assembly from one sampled snapshot
    always_comb begin
        next_err = 1'b1;
        next_pat = '0;
        case (cmd_w)
            // byte from any of four channels
            tipr_pkg::RD_BYTE: begin
                if (cmd_ch >= tipr_pkg::CH_FIRST && cmd_ch <= tipr_pkg::CH_LAST) begin
                    next_err = !dir_in[2'(cmd_ch - tipr_pkg::CH_FIRST)];
                    next_pat = {24'h000000,
                        ttl_s[tipr_pkg::LINES*(2'(cmd_ch - tipr_pkg::CH_FIRST)) +: 8]};
                end
            end
            // word from eleven or thirteen only
            tipr_pkg::RD_WORD: begin
                if (cmd_ch == tipr_pkg::CH_FIRST) begin
                    next_err = !(dir_in[0] && dir_in[1]);
                    next_pat = {16'h0000, ttl_s[15:0]};
                end else if (cmd_ch == tipr_pkg::CH_THIRD) begin
                    next_err = !(dir_in[2] && dir_in[3]);
                    next_pat = {16'h0000, ttl_s[31:16]};
                end
            end
            // double word addressed by eleven, ascending bytes
            tipr_pkg::RD_DWORD: begin
                if (cmd_ch == tipr_pkg::CH_FIRST) begin
                    next_err = !(&dir_in);
                    next_pat = ttl_s;
                end
            end
            default: begin
                next_err = 1'b1;
                next_pat = '0;
            end
        endcase
    end

    // latch coherent pattern, or error with zero pattern
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            result <= '0;
            done <= 1'b0;
        end else if (i_ce) begin
            if (cmd_fire) begin
                result.err <= next_err;
                result.pattern <= next_err ? '0 : next_pat;
                done <= 1'b1;
            end
        end
    end

    // digit truncation drops least significant digits
    function automatic logic [W-1:0] trunc(input logic [W-1:0] v,
                                           input tipr_pkg::tipr_base_t b,
                                           input logic [tipr_pkg::DIG_W-1:0] len);
        logic [W-1:0] r;
        logic [W-1:0] msk;
        int bits;
        int i;
        int top;
        r = v;
        msk = '1;
        bits = (b == tipr_pkg::BASE2) ? 1 : (b == tipr_pkg::BASE8) ? 3 : 4;
        top = 0;
        for (i = 0; i < W; i++) begin
            if (v[i]) begin
                top = i;
            end
        end
        // digits held in the value, then shift down the excess
        if (len != '0 && b != tipr_pkg::BASE10) begin
            if ((top / bits + 1) > int'(len)) begin
                r = v >> (((top / bits + 1) - int'(len)) * bits);
            end
        end
        trunc = r & msk;
    endfunction

    // decimal digits are formed by the host-side formatter; binary value passes through
    assign fmt_pat = trunc(result.pattern, fmt.base, fmt.length);

    always_comb begin
        pfx_word = '0;
        case (fmt.base)
            tipr_pkg::BASE2: pfx_word = {24'h000023, tipr_pkg::PFX_BIN};
            tipr_pkg::BASE16: pfx_word = {24'h000023, tipr_pkg::PFX_HEX};
            tipr_pkg::BASE8: pfx_word = {24'h000023, tipr_pkg::PFX_OCT};
            default: pfx_word = '0;
        endcase
    end

    // axi read path; unmapped addresses answer slverr
    assign s_axi_arready = i_ce && !s_axi_rvalid;

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = tipr_pkg::RESP_OKAY;
        if (s_axi_araddr == tipr_pkg::ADDR_DIR) begin
            next_rdata = {28'h0000000, dir_in};
        end else if (s_axi_araddr == tipr_pkg::ADDR_FMT) begin
            next_rdata = {16'h0000, 2'h0, fmt.length, 6'h00, fmt.base};
        end else if (s_axi_araddr == tipr_pkg::ADDR_CMD) begin
            next_rdata = pfx_word;
        end else if (s_axi_araddr == tipr_pkg::ADDR_STAT) begin
            next_rdata = {30'h00000000, done, result.err};
        end else if (s_axi_araddr == tipr_pkg::ADDR_PAT) begin
            next_rdata = fmt_pat;
        end else if (s_axi_araddr == tipr_pkg::ADDR_PANEL) begin
            next_rdata = {21'h000000, o_panel_base, o_panel_in_mark, o_panel_byte};
        end else begin
            next_rresp = tipr_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= tipr_pkg::RESP_OKAY;
        end else if (i_ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rresp;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // panel path offers byte reads only
    // input marker beside each input-port reading
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_panel_valid <= 1'b0;
            o_panel_byte <= 8'h00;
            o_panel_in_mark <= 1'b0;
            o_panel_base <= tipr_pkg::BASE10;
            o_panel_err <= 1'b0;
        end else if (i_ce) begin
            o_panel_valid <= i_panel_rd;
            if (i_panel_rd) begin
                if (i_panel_ch >= tipr_pkg::CH_FIRST && i_panel_ch <= tipr_pkg::CH_LAST &&
                    dir_in[2'(i_panel_ch - tipr_pkg::CH_FIRST)]) begin
                    o_panel_byte <= ttl_s[tipr_pkg::LINES*(2'(i_panel_ch -
                        tipr_pkg::CH_FIRST)) +: 8];
                    o_panel_in_mark <= 1'b1;
                    o_panel_err <= 1'b0;
                end else begin
                    o_panel_byte <= 8'h00;
                    o_panel_in_mark <= 1'b0;
                    o_panel_err <= 1'b1;
                end
                o_panel_base <= (fmt.base == tipr_pkg::BASE2) ? tipr_pkg::BASE16 : fmt.base;
            end
        end
    end
endmodule

// File: tipr_top_assertions.sv
// concurrent checks on the reader's panel and axi ports
`timescale 1ns/1ps
module tipr_chk (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [31:0] i_ttl,
    input wire logic i_panel_rd,
    input wire logic [7:0] i_panel_ch,
    input wire logic o_panel_valid,
    input wire logic [7:0] o_panel_byte,
    input wire logic o_panel_in_mark,
    input wire logic [1:0] o_panel_base,
    input wire logic o_panel_err,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [31:0] ttl_d1;
    logic [31:0] ttl_d2;
    logic [31:0] ttl_d3;
    logic [7:0] ch_d;
    logic [1:0] idx;
    // two sync flops plus the panel register
    always_ff @(posedge i_clk_sys) begin
        ttl_d1 <= i_ttl;
        ttl_d2 <= ttl_d1;
        ttl_d3 <= ttl_d2;
        ch_d <= i_panel_ch;
    end
    assign idx = ch_d[1:0] - 2'h3;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);
    a_panel_answer:
        assert property (i_panel_rd |=> o_panel_valid) else $error("panel read not answered");
    a_panel_single:
        assert property (o_panel_valid |-> $past(i_panel_rd))
        else $error("panel valid without request");
    a_panel_no_bin:
        assert property (o_panel_valid |-> o_panel_base != tipr_pkg::BASE2)
        else $error("panel shows binary base");
    a_bad_chan_err:
        assert property (i_panel_rd && (i_panel_ch < tipr_pkg::CH_FIRST
            || i_panel_ch > tipr_pkg::CH_LAST) |=> o_panel_err) else $error("bad channel taken");
    a_err_no_data:
        assert property (o_panel_valid && o_panel_err
            |-> o_panel_byte == 8'h00 && !o_panel_in_mark)
        else $error("error reading carries data");
    a_input_mark:
        assert property (o_panel_valid && !o_panel_err |-> o_panel_in_mark)
        else $error("input reading lacks marker");
    a_byte_order:
        assert property (o_panel_valid && !o_panel_err |-> o_panel_byte == ttl_d3[idx*8 +: 8])
        else $error("panel byte differs from port lines");
    a_read_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_read_release:
        assert property (s_axi_rvalid && s_axi_rready && i_ce |=> !s_axi_rvalid)
        else $error("read response not released");
    a_write_resp:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:3] s_axi_bvalid) else $error("write response missing");
    a_bresp_hold:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
endmodule
bind tipr_top tipr_chk u_tipr_chk (.i_clk_sys, .i_rstn, .i_ttl, .i_panel_rd, .i_panel_ch,
    .o_panel_valid, .o_panel_byte, .o_panel_in_mark, .o_panel_base, .o_panel_err,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .i_ce);

// File: tipr_ttl_src.sv
// behavioural ttl sources on the four port connectors
`timescale 1ns/1ps
module tipr_ttl_src (
    input wire logic [tipr_pkg::PAT_W-1:0] i_level,
    output logic [tipr_pkg::PAT_W-1:0] o_ttl
);
    // every line actively driven: high above 2 v, low below 0.8 v, none left floating
    assign o_ttl = i_level;
endmodule
